// [conv_pkg.sv]
package conv_pkg;
  // ------------------------------------------------------------
  // opcodes
  // ------------------------------------------------------------
  localparam logic [7:0] OP_START = 8'h08;
  localparam logic [7:0] OP_STOP = 8'h0A;
  localparam logic [7:0] OP_RESET = 8'h06;
  localparam logic [2:0] OP_REGISTER_WRITE_CMD_TOP = 3'h2;

  // ------------------------------------------------------------
  // device register addresses, fields and reset values
  // ------------------------------------------------------------
  localparam logic [4:0] REG_MAIN = 5'h01;
  localparam logic [4:0] REG_RESP_A = 5'h09;
  localparam logic [4:0] REG_RESP_B = 5'h0A;
  localparam logic [4:0] REG_DIV = 5'h0B;
  localparam logic [4:0] REG_GPIO = 5'h0C;
  localparam int SINGLE_BIT = 7;
  localparam int DIV_BIT = 6;
  localparam int GPIO_DIR_LSB = 2;
  localparam logic [7:0] MAIN_RESET = 8'h02;
  localparam logic [7:0] RESP_A_RESET = 8'h00;
  localparam logic [7:0] RESP_B_RESET = 8'h00;
  localparam logic [7:0] DIV_RESET = 8'h00;
  localparam logic [1:0] GPIO_DIR_RESET = 2'h3;
  localparam logic [23:0] STATUS_HEAD = 24'hC00000;
  localparam int STATUS_GPIO_LSB = 13;

  // ------------------------------------------------------------
  // timing, in device clocks and modulator periods
  // ------------------------------------------------------------
  localparam int CLK_NS = 20;
  localparam int MOD_CLKS_FAST = 4;
  localparam int MOD_CLKS_SLOW = 16;
  localparam logic [3:0] MOD_LAST_FAST = 4'(MOD_CLKS_FAST - 1);
  localparam logic [3:0] MOD_LAST_SLOW = 4'(MOD_CLKS_SLOW - 1);
  localparam logic [9:0] PD_MODS = 10'h200;
  localparam logic [4:0] INIT_LAST = 5'(18 - 1);
  localparam logic [12:0] HALT_SETUP_MODS = 13'h0008;
  localparam logic [12:0] FILTER_OFFSET_MODS = 13'h0004;
  localparam int SCLK_HALF_CLKS = 4;
  localparam logic [2:0] HALF_LAST = 3'(SCLK_HALF_CLKS - 1);

  // ------------------------------------------------------------
  // host register map
  // ------------------------------------------------------------
  localparam logic [1:0] HOST_CTRL = 2'h0;
  localparam logic [1:0] HOST_TX = 2'h1;
  localparam logic [1:0] HOST_STAT = 2'h2;
  localparam logic [1:0] HOST_GPIO = 2'h3;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_PWDN_BIT = 1;
  localparam int CTRL_CMD_BIT = 2;
  localparam int CTRL_RESTART_BIT = 3;
  localparam int TX_KEEP_CS_BIT = 8;

  // settling delay in modulator periods; the undefined code runs as 110
  function automatic logic [12:0] settle_mods(input logic [2:0] rate);
    case (rate)
      3'h0: settle_mods = 13'h1004;
      3'h1: settle_mods = 13'h0804;
      3'h2: settle_mods = 13'h0404;
      3'h3: settle_mods = 13'h0204;
      3'h4: settle_mods = 13'h0104;
      3'h5: settle_mods = 13'h0084;
      default: settle_mods = 13'h0044;
    endcase
  endfunction

  // one data period: the filter needs four of them plus the offset
  function automatic logic [12:0] period_mods(input logic [2:0] rate);
    period_mods = (settle_mods(rate) - FILTER_OFFSET_MODS) >> 2;
  endfunction
endpackage

// [conv_link_if.sv]
`timescale 1ns/10ps
interface conv_link_if;
  logic cs_n;
  logic sclk;
  logic din;
  logic dout;
  logic dout_oe;
  logic data_ready_n;
  logic start;
  logic powerdown_reset_n;
  logic [1:0] gpio_dev_out;
  logic [1:0] gpio_dev_oe;
  logic [1:0] gpio_host_out;
  logic [1:0] gpio_host_oe;
  logic [1:0] gpio_level;

  // an undriven pin reads low
  assign gpio_level = (gpio_dev_oe & gpio_dev_out) |
                      (~gpio_dev_oe & gpio_host_oe & gpio_host_out);

  modport device(
    input cs_n, sclk, din, start, powerdown_reset_n, gpio_level,
    output dout, dout_oe, data_ready_n, gpio_dev_out, gpio_dev_oe
  );
  modport host(
    output cs_n, sclk, din, start, powerdown_reset_n,
    output gpio_host_out, gpio_host_oe,
    input dout, dout_oe, data_ready_n, gpio_level
  );
endinterface

// [conv_device.sv]
`timescale 1ns/10ps
// What this block does
// - data ready low on new results, any select
// - data ready high on first falling serial clock
// - two pins, direction and level bits separate
// - level read returns actual pin levels
// - level write drives outputs, ignored on inputs
// - pins are inputs after any reset
// - power down after reset low over 512 periods
// - every falling reset pin edge resets device
// - reset command acts on eighth falling edge
// - 18 clocks of init after reset
// - changed config writes reset the filter
// - no start, no conversions, no data ready
// - config bit 7 selects one-shot mode
// - start raises data ready until settled data
// - settling delay set by the rate code
// - fourth data ready after step is settled
// - host waits one slow period after data ready falls before serial clocks
// - continuous until stop, current one finishes
// - start and stop act on seventh edge
// - host stops eight periods before data ready
// - host restarts start when entering continuous
// - host holds start pin low in command use
module conv_device
  import conv_pkg::*;
#(
  // divides settling and data periods to shorten simulations
  parameter int settle_div = 1
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // link to the host
  conv_link_if.device link,
  // user side
  output logic powered_down_out,
  output logic converting_out,
  output logic conversion_done_out,
  output logic filter_reset_out,
  output logic [7:0] main_config_out
);
  typedef enum logic [1:0] {S_INIT, S_IDLE, S_RUN} conv_state_t;
  typedef enum logic [1:0] {P_OPCODE, P_COUNT, P_DATA} parse_state_t;

  logic sclk_q, start_q;
  logic sclk_fall, sclk_rise, start_rise;
  logic [6:0] shift_in;
  logic [2:0] bit_cnt;
  logic [7:0] rx_byte;
  logic [6:0] rx_seven;
  parse_state_t parse;
  logic [4:0] wr_addr, wr_left;
  logic wr_en, start_cmd, stop_cmd, reset_cmd, soft_rst, filter_rst;
  logic [7:0] main_cfg, resp_a, resp_b, div_cfg;
  logic [1:0] gpio_dir, gpio_drive, new_dir;
  logic [3:0] mod_cnt, mod_last;
  logic mod_tick;
  logic [9:0] pd_cnt;
  logic [4:0] init_cnt;
  conv_state_t state;
  logic [12:0] remain, settle_now, period_now;
  logic halt, cmd_run, run_level, single, go, conv_done;
  logic [23:0] out_sh;

  // ------------------------------------------------------------
  // pin edges
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sclk_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      sclk_q <= link.sclk;
      start_q <= link.start;
    end
  end

  assign sclk_fall = sclk_q & ~link.sclk;
  assign sclk_rise = ~sclk_q & link.sclk;
  assign start_rise = link.start & ~start_q;
  assign rx_byte = {shift_in, link.din};
  assign rx_seven = {shift_in[5:0], link.din};

  // ------------------------------------------------------------
  // serial input and command decode
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      shift_in <= 7'h00;
      bit_cnt <= 3'h0;
    end else if (link.cs_n) begin
      bit_cnt <= 3'h0;
    end else if (sclk_fall) begin
      shift_in <= rx_byte[6:0];
      bit_cnt <= bit_cnt + 3'h1;
    end
  end

  always_comb begin
    start_cmd = 1'b0;
    stop_cmd = 1'b0;
    reset_cmd = 1'b0;
    wr_en = 1'b0;
    if (!link.cs_n && sclk_fall) begin
      if (parse == P_OPCODE && bit_cnt == 3'h6) begin
        start_cmd = (rx_seven == OP_START[7:1]);
        stop_cmd = (rx_seven == OP_STOP[7:1]);
      end
      if (bit_cnt == 3'h7) begin
        reset_cmd = (parse == P_OPCODE) && (rx_byte == OP_RESET);
        wr_en = (parse == P_DATA);
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      parse <= P_OPCODE;
      wr_addr <= 5'h00;
      wr_left <= 5'h00;
    end else if (link.cs_n) begin
      parse <= P_OPCODE;
    end else if (sclk_fall && bit_cnt == 3'h7) begin
      case (parse)
        P_OPCODE: begin
          if (rx_byte[7:5] == OP_REGISTER_WRITE_CMD_TOP) begin
            wr_addr <= rx_byte[4:0];
            parse <= P_COUNT;
          end
        end
        P_COUNT: begin
          wr_left <= rx_byte[4:0];
          parse <= P_DATA;
        end
        P_DATA: begin
          wr_addr <= wr_addr + 5'h01;
          wr_left <= wr_left - 5'h01;
          if (wr_left == 5'h00) begin
            parse <= P_OPCODE;
          end
        end
        default: parse <= P_OPCODE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // reset, power down and registers
  // ------------------------------------------------------------
  // pin low holds reset
  assign soft_rst = reset_cmd | ~link.powerdown_reset_n;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pd_cnt <= 10'h000;
      powered_down_out <= 1'b0;
    end else if (link.powerdown_reset_n) begin
      pd_cnt <= 10'h000;
      powered_down_out <= 1'b0;
    end else if (mod_tick) begin
      if (pd_cnt == PD_MODS) begin
        powered_down_out <= 1'b1;
      end else begin
        pd_cnt <= pd_cnt + 10'h001;
      end
    end
  end

  assign new_dir = rx_byte[GPIO_DIR_LSB +: 2];
  // only a changed value resets the filter
  assign filter_rst = wr_en &&
    ((wr_addr == REG_MAIN && rx_byte != main_cfg) ||
     (wr_addr == REG_RESP_A && rx_byte != resp_a) ||
     (wr_addr == REG_RESP_B && rx_byte != resp_b));

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      main_cfg <= MAIN_RESET;
      resp_a <= RESP_A_RESET;
      resp_b <= RESP_B_RESET;
      div_cfg <= DIV_RESET;
      gpio_dir <= GPIO_DIR_RESET;
      gpio_drive <= 2'h0;
    end else if (soft_rst) begin
      main_cfg <= MAIN_RESET;
      resp_a <= RESP_A_RESET;
      resp_b <= RESP_B_RESET;
      div_cfg <= DIV_RESET;
      gpio_dir <= GPIO_DIR_RESET;
      gpio_drive <= 2'h0;
    end else if (wr_en) begin
      case (wr_addr)
        REG_MAIN: main_cfg <= rx_byte;
        REG_RESP_A: resp_a <= rx_byte;
        REG_RESP_B: resp_b <= rx_byte;
        REG_DIV: div_cfg <= rx_byte;
        REG_GPIO: begin
          gpio_dir <= new_dir;
          gpio_drive <= (rx_byte[1:0] & ~new_dir) | (gpio_drive & new_dir);
        end
        default: ;
      endcase
    end
  end

  assign link.gpio_dev_out = gpio_drive;
  assign link.gpio_dev_oe = ~gpio_dir;

  // ------------------------------------------------------------
  // modulator period and conversion sequencing
  // ------------------------------------------------------------
  assign mod_last = div_cfg[DIV_BIT] ? MOD_LAST_SLOW : MOD_LAST_FAST;
  assign mod_tick = (mod_cnt == mod_last);

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mod_cnt <= 4'h0;
    end else if (mod_cnt >= mod_last) begin
      mod_cnt <= 4'h0;
    end else begin
      mod_cnt <= mod_cnt + 4'h1;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cmd_run <= 1'b0;
    end else if (soft_rst || stop_cmd) begin
      cmd_run <= 1'b0;
    end else if (start_cmd) begin
      cmd_run <= 1'b1;
    end
  end

  assign single = main_cfg[SINGLE_BIT];
  assign run_level = link.start | cmd_run;
  assign settle_now = 13'(settle_mods(main_cfg[2:0]) / settle_div);
  // later results one data period apart
  assign period_now = 13'(period_mods(main_cfg[2:0]) / settle_div);
  // a start command while converting continuously does not restart the conversion
  assign go = start_rise | filter_rst |
              (start_cmd & (state != S_RUN | single));
  // a reset in the same cycle drops the result
  assign conv_done = (state == S_RUN) && !go && mod_tick && !soft_rst &&
                     (remain <= 13'h0001);

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= S_INIT;
      init_cnt <= 5'h00;
      remain <= 13'h0000;
      halt <= 1'b0;
    end else if (soft_rst) begin
      state <= S_INIT;
      init_cnt <= 5'h00;
      halt <= 1'b0;
    end else begin
      case (state)
        S_INIT: begin
          if (init_cnt == INIT_LAST) begin
            state <= run_level ? S_RUN : S_IDLE;
            remain <= settle_now;
          end else begin
            init_cnt <= init_cnt + 5'h01;
          end
        end
        S_IDLE: begin
          // a filter reset alone never starts a conversion
          if (start_rise || start_cmd) begin
            state <= S_RUN;
            remain <= settle_now;
            halt <= 1'b0;
          end
        end
        S_RUN: begin
          if (go) begin
            remain <= settle_now;
            halt <= 1'b0;
          end else if (mod_tick) begin
            // late stops let the next one run
            if (remain > HALT_SETUP_MODS && !run_level) begin
              halt <= 1'b1;
            end
            if (remain <= 13'h0001) begin
              if (halt || single) begin
                state <= S_IDLE;
              end
              remain <= period_now;
              // a stop too late for this one ends the next
              halt <= !run_level;
            end else begin
              remain <= remain - 13'h0001;
            end
          end
        end
        default: state <= S_INIT;
      endcase
    end
  end

  // ------------------------------------------------------------
  // data ready and serial output
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      link.data_ready_n <= 1'b1;
    end else if (conv_done) begin
      link.data_ready_n <= 1'b0;
    end else if (sclk_fall || go || soft_rst) begin
      // high on serial clock or start
      link.data_ready_n <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      out_sh <= 24'h000000;
      link.dout <= 1'b0;
    end else if (link.cs_n) begin
      out_sh <= STATUS_HEAD |
                (24'(link.gpio_level) << STATUS_GPIO_LSB);
    end else if (sclk_rise) begin
      link.dout <= out_sh[23];
      out_sh <= {out_sh[22:0], out_sh[23]};
    end
  end

  assign link.dout_oe = ~link.cs_n;
  assign converting_out = (state == S_RUN);
  assign conversion_done_out = conv_done;
  assign filter_reset_out = filter_rst;
  assign main_config_out = main_cfg;
endmodule

// [conv_host.sv]
`timescale 1ns/10ps
module conv_host
  import conv_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // register port
  input wire logic [1:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  // link to the device
  conv_link_if.host link
);
  typedef enum logic [2:0] {H_IDLE, H_WAIT, H_HIGH, H_LOW, H_END} host_state_t;

  host_state_t state;
  logic ctrl_start, ctrl_pwdn, ctrl_cmd, restart;
  logic [1:0] gpio_out, gpio_oe;
  logic [7:0] tx, rx;
  logic keep;
  logic [2:0] half;
  logic [3:0] bits;
  logic [4:0] since_fall;
  logic busy;

  assign busy = (state != H_IDLE);

  // ------------------------------------------------------------
  // control registers and pins
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl_start <= 1'b0;
      ctrl_pwdn <= 1'b1;
      ctrl_cmd <= 1'b0;
      restart <= 1'b0;
      gpio_out <= 2'h0;
      gpio_oe <= 2'h0;
    end else begin
      restart <= 1'b0;
      if (wr_in && addr_in == HOST_CTRL) begin
        ctrl_start <= wdata_in[CTRL_START_BIT];
        ctrl_pwdn <= wdata_in[CTRL_PWDN_BIT];
        ctrl_cmd <= wdata_in[CTRL_CMD_BIT];
        restart <= wdata_in[CTRL_RESTART_BIT];
      end
      if (wr_in && addr_in == HOST_GPIO) begin
        gpio_out <= wdata_in[1:0];
        gpio_oe <= wdata_in[3:2];
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      link.start <= 1'b0;
      link.powerdown_reset_n <= 1'b1;
      link.gpio_host_out <= 2'h0;
      link.gpio_host_oe <= 2'h0;
    end else begin
      // restart dips start for one cycle
      link.start <= ctrl_start & ~ctrl_cmd & ~restart;
      link.powerdown_reset_n <= ctrl_pwdn;
      link.gpio_host_out <= gpio_out;
      link.gpio_host_oe <= gpio_oe;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      since_fall <= 5'h00;
    end else if (link.data_ready_n) begin
      since_fall <= 5'h00;
    end else if (since_fall < 5'(MOD_CLKS_SLOW)) begin
      since_fall <= since_fall + 5'h01;
    end
  end

  // ------------------------------------------------------------
  // serial byte engine
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= H_IDLE;
      link.cs_n <= 1'b1;
      link.sclk <= 1'b0;
      link.din <= 1'b0;
      tx <= 8'h00;
      rx <= 8'h00;
      keep <= 1'b0;
      half <= 3'h0;
      bits <= 4'h0;
    end else begin
      case (state)
        H_IDLE: begin
          if (wr_in && addr_in == HOST_TX) begin
            tx <= wdata_in[7:0];
            keep <= wdata_in[TX_KEEP_CS_BIT];
            link.cs_n <= 1'b0;
            bits <= 4'h0;
            state <= H_WAIT;
          end
        end
        H_WAIT: begin
          // one slow period after data ready falls
          if (link.data_ready_n || since_fall >= 5'(MOD_CLKS_SLOW)) begin
            half <= 3'h0;
            link.sclk <= 1'b1;
            link.din <= tx[7];
            state <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (half == HALF_LAST) begin
            half <= 3'h0;
            link.sclk <= 1'b0;
            rx <= {rx[6:0], link.dout};
            tx <= {tx[6:0], 1'b0};
            bits <= bits + 4'h1;
            state <= H_LOW;
          end else begin
            half <= half + 3'h1;
          end
        end
        H_LOW: begin
          if (half != HALF_LAST) begin
            half <= half + 3'h1;
          end else if (bits == 4'h8) begin
            state <= H_END;
          end else begin
            half <= 3'h0;
            link.sclk <= 1'b1;
            link.din <= tx[7];
            state <= H_HIGH;
          end
        end
        H_END: begin
          link.cs_n <= ~keep;
          link.din <= 1'b0;
          state <= H_IDLE;
        end
        default: state <= H_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out <= 16'h0000;
    end else if (!rd_in) begin
      rdata_out <= 16'h0000;
    end else begin
      case (addr_in)
        HOST_CTRL: rdata_out <= {13'h0000, ctrl_cmd, ctrl_pwdn, ctrl_start};
        HOST_TX: rdata_out <= {8'h00, tx};
        HOST_STAT: rdata_out <= {rx, 4'h0, link.gpio_level,
                                 link.data_ready_n, busy};
        HOST_GPIO: rdata_out <= {12'h000, gpio_oe, gpio_out};
        default: rdata_out <= 16'h0000;
      endcase
    end
  end
endmodule

// [conv_link_assertions.sv]
`timescale 1ns/10ps
module conv_link_assertions (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // watched link and device signals
  input wire logic sclk,
  input wire logic start,
  input wire logic powerdown_reset_n,
  input wire logic data_ready_n,
  input wire logic [1:0] gpio_dev_oe,
  input wire logic conversion_done_out,
  input wire logic powered_down_out
);
  // ------------------------------------------------------------
  // reset pin low time
  // ------------------------------------------------------------
  logic [11:0] low_cnt;
  // saturates so a long power down never wraps back into the early band
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      low_cnt <= 12'h000;
    end else if (powerdown_reset_n) begin
      low_cnt <= 12'h000;
    end else if (low_cnt != 12'hFFF) begin
      low_cnt <= low_cnt + 12'h001;
    end
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  data_ready_n_clear_a: assert property ($fell(sclk) |-> ##2 (data_ready_n ||
    $past(conversion_done_out) || $past(conversion_done_out, 2)))
    else $error("data ready not high after sclk fall");
  data_ready_n_set_a: assert property (conversion_done_out |=> !data_ready_n)
    else $error("data ready not low after a result");
  start_raise_a: assert property ($rose(start) |-> ##2 (data_ready_n
    || $past(conversion_done_out) || $past(conversion_done_out, 2)))
    else $error("data ready not high after start");
  reset_data_ready_n_a: assert property ($fell(powerdown_reset_n) |->
    ##2 data_ready_n) else $error("pin reset left data ready low");
  reset_gpio_a: assert property ($fell(powerdown_reset_n) |->
    ##2 gpio_dev_oe == 2'h0) else $error("pins not inputs after reset");
  pd_early_a: assert property (low_cnt < 12'd2040 |->
    !powered_down_out) else $error("power down too early");
  pd_late_a: assert property (low_cnt == 12'd2070 |->
    powered_down_out) else $error("power down missing");
  pd_clear_a: assert property ($rose(powerdown_reset_n) |->
    ##3 !powered_down_out) else $error("power down not cleared");
endmodule

// [conversion_start_ready_control_tb_top.sv]
`timescale 1ns/10ps
module conversion_start_ready_control_tb_top;
  import conv_pkg::*;
  // ------------------------------------------------------------
  // signals and instances
  // ------------------------------------------------------------
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [1:0] addr_in = 2'h0;
  logic [15:0] wdata_in = 16'h0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [15:0] rdata_out, rv;
  logic powered_down_out, conversion_done_out, filter_reset_out, converting_out;
  logic [7:0] main_config_out;
  logic [31:0] seed = 32'hBF17;
  int fail_count = 0, comparisons = 0, dones = 0, resets = 0, n;
  conv_link_if i_conv_link_if();
  conv_device #(.settle_div(16)) i_conv_device(.clk_in(clk_in),
    .nrst_in(nrst_in), .link(i_conv_link_if.device),
    .powered_down_out(powered_down_out), .converting_out(converting_out),
    .conversion_done_out(conversion_done_out),
    .filter_reset_out(filter_reset_out), .main_config_out(main_config_out));
  conv_host i_conv_host(.clk_in(clk_in), .nrst_in(nrst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .link(i_conv_link_if.host));
  conv_link_assertions i_conv_link_assertions(.clk_in(clk_in),
    .nrst_in(nrst_in), .sclk(i_conv_link_if.sclk),
    .start(i_conv_link_if.start),
    .powerdown_reset_n(i_conv_link_if.powerdown_reset_n),
    .data_ready_n(i_conv_link_if.data_ready_n),
    .gpio_dev_oe(i_conv_link_if.gpio_dev_oe),
    .conversion_done_out(conversion_done_out),
    .powered_down_out(powered_down_out));
  initial forever #10 clk_in = ~clk_in;
  always @(posedge clk_in) if (conversion_done_out === 1'b1) dones++;
  always @(posedge clk_in) if (filter_reset_out === 1'b1) resets++;
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
  endfunction
  // settle in clocks, divided by 16 as the design is set up
  function automatic int settle_clks(input int r);
    int tbl[8] = '{4100, 2052, 1028, 516, 260, 132, 68, 68};
    settle_clks = tbl[r] / 16 * 4;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(negedge clk_in);
    d = rdata_out;
  endtask
  task automatic send(input logic [7:0] b, input logic keep);
    wr(HOST_TX, {7'h00, keep, b});
    rv = 16'h0001;
    for (int i = 0; i < 200 && rv[0] !== 1'b0; i++) rd(HOST_STAT, rv);
    if (rv[0] !== 1'b0) begin
      fail_count++;
      $display("unexpected at %0t: byte engine stuck", $time);
    end
  endtask
  task automatic register_write_cmd(input logic [4:0] a, input logic [7:0] d);
    send({OP_REGISTER_WRITE_CMD_TOP, a}, 1'b1);
    send(8'h00, 1'b1);
    send(d, 1'b0);
  endtask
  task automatic wait_data_ready_n(output int t);
    t = 0;
    while (i_conv_link_if.data_ready_n !== 1'b0 && t < 3000) begin
      @(posedge clk_in);
      t++;
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    #2000000;
    fail_count++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (20) @(posedge clk_in);
    rd(HOST_STAT, rv);
    chk(16'(rv[1:0]), 16'h0002);
    for (int k = 0; k < 4; k++) begin
      seed = xs(seed);
      wr(HOST_GPIO, 16'h0000);
      register_write_cmd(REG_GPIO, {4'h0, 2'h0, seed[3:2]});
      rd(HOST_STAT, rv);
      chk(16'(rv[3:2]), 16'(seed[3:2]));
      // second status byte holds the pin levels at bits 6:5
      send(8'h00, 1'b1);
      send(8'h00, 1'b0);
      rd(HOST_STAT, rv);
      chk(16'(rv[15:8]), 16'({1'b0, seed[3:2], 5'h00}));
      // pin 0 input driven by the host, pin 1 still an output
      wr(HOST_GPIO, {12'h000, 2'h1, seed[5:4]});
      register_write_cmd(REG_GPIO, {4'h0, 2'h1, ~seed[5:4]});
      rd(HOST_STAT, rv);
      chk(16'(rv[3:2]), 16'({~seed[5], seed[4]}));
    end
    for (int r = 0; r < 8; r++) begin
      wr(HOST_CTRL, 16'h0002);
      register_write_cmd(REG_MAIN, {5'h00, 3'(r)});
      wr(HOST_CTRL, 16'h0003);
      wait_data_ready_n(n);
      chk(16'(n > settle_clks(r) - 12 && n < settle_clks(r) + 12),
        16'h0001);
    end
    wr(HOST_CTRL, 16'h0002);
    register_write_cmd(REG_MAIN, 8'h86);
    wr(HOST_CTRL, 16'h0003);
    wait_data_ready_n(n);
    repeat (200) @(posedge clk_in);
    chk(16'(i_conv_link_if.data_ready_n), 16'h0000);
    send(8'h00, 1'b0);
    repeat (200) @(posedge clk_in);
    chk(16'(i_conv_link_if.data_ready_n), 16'h0001);
    register_write_cmd(REG_MAIN, 8'h06);
    n = dones;
    // leaving one-shot mode needs a fresh start edge
    wr(HOST_CTRL, 16'h000B);
    repeat (300) @(posedge clk_in);
    chk(16'(dones - n > 60 && dones - n < 80), 16'h0001);
    chk(16'(converting_out), 16'h0001);
    wr(HOST_CTRL, 16'h0002);
    repeat (40) @(posedge clk_in);
    n = dones;
    repeat (300) @(posedge clk_in);
    chk(16'(dones - n), 16'h0000);
    chk(16'(converting_out), 16'h0000);
    // command control keeps the start pin low
    wr(HOST_CTRL, 16'h0006);
    n = dones;
    send(OP_START, 1'b0);
    repeat (100) @(posedge clk_in);
    chk(16'(dones > n), 16'h0001);
    send(OP_STOP, 1'b0);
    repeat (40) @(posedge clk_in);
    n = dones;
    repeat (200) @(posedge clk_in);
    chk(16'(dones - n), 16'h0000);
    n = resets;
    register_write_cmd(REG_RESP_A, 8'h5A);
    register_write_cmd(REG_RESP_A, 8'h5A);
    register_write_cmd(REG_RESP_B, 8'hA5);
    chk(16'(resets - n), 16'h0002);
    register_write_cmd(REG_MAIN, 8'h85);
    send(OP_RESET, 1'b0);
    repeat (30) @(posedge clk_in);
    chk(16'(main_config_out), 16'(MAIN_RESET));
    wr(HOST_GPIO, 16'h0000);
    register_write_cmd(REG_GPIO, 8'h01);
    register_write_cmd(REG_MAIN, 8'h85);
    wr(HOST_CTRL, 16'h0001);
    repeat (2100) @(posedge clk_in);
    chk(16'(powered_down_out), 16'h0001);
    wr(HOST_GPIO, 16'h000E);
    rd(HOST_STAT, rv);
    chk(16'(rv[3:2]), 16'h0002);
    wr(HOST_CTRL, 16'h0002);
    repeat (30) @(posedge clk_in);
    chk(16'(powered_down_out), 16'h0000);
    chk(16'(main_config_out), 16'(MAIN_RESET));
    print_verdict();
  end
endmodule
